/* flash_host_model.sv */
`timescale 1ns/10ps
module flash_host_model (
  input  wire logic       clk,
  input  wire logic [3:0] ioOut,
  input  wire logic [3:0] ioOe_n,
  output logic            serialClock,
  output logic            chipSelect_n,
  output logic [3:0]      ioIn
);
  logic [3:0] hostEn = 4'hC;
  logic [3:0] hostD = 4'hC;
  logic [3:0] floatPat = 4'h5;
  logic [7:0] smp[$];

  initial begin
    serialClock = 1'b0;
    chipSelect_n = 1'b1;
  end

  always @(posedge clk) floatPat <= ~floatPat;

  // a released line shows a changing pattern, never its last value
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ioIn[i] = !ioOe_n[i] ? ioOut[i] : hostEn[i] ? hostD[i] : floatPat[i];
    end
  end

  // one link cycle: data set while the clock is low, lines sampled at the rising edge
  task automatic cyc(input logic [3:0] en, input logic [3:0] d);
    hostEn = en;
    hostD = d;
    #16 serialClock = 1'b1;
    smp.push_back({ioOe_n, ioOut});
    #32 serialClock = 1'b0;
    #16;
  endtask : cyc

  task automatic frame(input logic [7:0] op, input bit four_wire_command_mode, input logic wp, input int nX,
                       input int nA, input int wA, input int nL, input int nO,
                       input logic [3:0] rel);
    smp.delete();
    #3 chipSelect_n = 1'b0;
    if (four_wire_command_mode) begin
      cyc(4'hF, op[7:4]);
      cyc(4'hF, op[3:0]);
    end else begin
      for (int i = 7; i >= 0; i--) cyc(4'hD, {1'b1, wp, 1'b0, op[i]});
    end
    repeat (nX) cyc(4'hD, {3'b110, 1'($urandom)});
    repeat (nA) cyc(wA == 1 ? 4'hD : 4'hF, wA == 4 ? 4'($urandom) : {2'b11, 2'($urandom)});
    repeat (nL + nO) cyc(rel, 4'hC);
    #8 chipSelect_n = 1'b1;
    hostEn = 4'hC;
    hostD = 4'hC;
  endtask : frame
endmodule : flash_host_model

/* flash_if_states.sv */
`timescale 1ns/10ps
module flash_if_states #(
  parameter int POWER_UP_NS = flash_if_pkg::POWER_UP_NS_DEFAULT,
  parameter int CNT_W       = 16
) (
  input  logic               clk,
  input  logic               reset_n,
  input  logic               vccAboveLow,
  input  logic               vccAboveCutoff,
  input  logic               vccAboveMin,
  input  logic               resetPin_n,
  input  logic               io3ResetEnable,
  input  logic               quadEnable,
  input  logic               fourWireMode,
  input  logic [3:0]         latencyCycles,
  input  logic [7:0]         readByte,
  input  logic               serialClock,
  input  logic               chipSelect_n,
  input  logic [3:0]         ioIn,
  output logic [3:0]         ioOut,
  output logic [3:0]         ioOe_n,
  output flash_if_pkg::pwr_t powerState,
  output logic               deviceReady,
  output logic               cmdValid,
  output logic               cmdRejected,
  output logic [7:0]         cmdCode,
  output logic               cmdWriteProtected
);
  import flash_if_pkg::*;

  localparam int POR_CYC = (POWER_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] POR_MAX   = CNT_W'(POR_CYC - 1);
  localparam logic [CNT_W-1:0] PULSE_MAX = CNT_W'(RESET_PULSE_CYC);
  localparam logic [CNT_W-1:0] PROC_MAX  = CNT_W'(RESET_PROCESSING_CYC);
  localparam logic [CNT_W-1:0] HOLD_MAX  = CNT_W'(RESET_HOLD_CYC);

  if (POR_CYC < 1 || POR_CYC >= 2**CNT_W || RESET_PROCESSING_CYC >= 2**CNT_W ||
      ADDR_BITS + MODE_BITS > 63) begin : g_bad_cfg
    $error("flash_if_states counters too narrow for the timing");
  end

  // ---------------- system clock domain ----------------
  pwr_t             powerState_r;
  pwr_t             pwrNxt;
  logic             linkHold_r;
  logic             ready_r;
  logic [CNT_W-1:0] porCnt_r;
  logic [CNT_W-1:0] pulseCnt_r;
  logic [CNT_W-1:0] procCnt_r;
  logic [CNT_W-1:0] holdCnt_r;
  logic             csPrev_r;
  logic             lastTag_r;
  logic             cmdValid_r;
  logic             cmdRejected_r;
  logic [7:0]       cmdCode_r;
  logic             cmdWp_r;
  logic             resetActive;
  logic             csRise;
  logic             frameEnd;

  // ---------------- link clock domain ----------------
  lnk_t       state_r;
  lnk_t       stateNxt;
  lnk_t       curState;
  fmt_t       fmt_r;
  fmt_t       fmtNxt;
  logic [5:0] cnt_r;
  logic [5:0] cntNxt;
  logic [5:0] curCnt;
  logic [7:0] cmd_r;
  logic [7:0] instrNxt;
  logic [7:0] curCmd;
  logic [2:0] mod_r;
  logic [2:0] modNxt;
  logic [2:0] curMod;
  logic       instrDone_r;
  logic       doneNxt;
  logic       wpCapt_r;
  logic       wpNxt;
  logic       fresh_r;
  logic       frameTgl_r;
  logic       frameClr;
  logic       isRead;
  logic [3:0] ioOut_r;
  logic [3:0] ioOe_n_r;
  logic [7:0] outSh_r;
  logic       outLoaded_r;
  logic [7:0] shCur;
  logic [7:0] shNext;
  logic [3:0] drive;
  logic [3:0] outMask;
  logic       io0;

  // synchronised pins and link results seen by the system clock
  logic       csS;
  logic       rstPinS_n;
  logic       io3S;
  logic       vccLowS;
  logic       vccCutS;
  logic       vccMinS;
  logic       tagS;
  logic       instrDoneS;
  logic       isReadS;
  logic       alignedS;
  logic       wpS;
  logic [7:0] cmdS;
  // configuration as seen by the link clock
  logic       quadS;
  logic       qpiS;
  logic [3:0] latS;
  logic [7:0] readS;

  flash_if_sync #(.WIDTH(19)) u_sys_sync (
    .clk   (clk),
    .clear (1'b0),
    .d     ({chipSelect_n, resetPin_n, ioIn[IO_RST_IDX], vccAboveLow, vccAboveCutoff,
             vccAboveMin, frameTgl_r, instrDone_r, isRead, (mod_r == 3'h0), wpCapt_r,
             cmd_r}),
    .q     ({csS, rstPinS_n, io3S, vccLowS, vccCutS, vccMinS, tagS, instrDoneS,
             isReadS, alignedS, wpS, cmdS})
  );

  flash_if_sync #(.WIDTH(14)) u_link_sync (
    .clk   (serialClock),
    .clear (linkHold_r),
    .d     ({quadEnable, fourWireMode, latencyCycles, readByte}),
    .q     ({quadS, qpiS, latS, readS})
  );

  function automatic logic [5:0] addrCycOf(input fmt_t f, input logic four_wire_command_mode);
    int bits;
    int w;
    begin
      bits = ADDR_BITS;
      w    = 1;
      case (f)
        FMT_DUAL_IO: begin
          bits = ADDR_BITS + MODE_BITS;
          w    = 2;
        end
        FMT_QUAD_IO: begin
          bits = ADDR_BITS + MODE_BITS;
          w    = 4;
        end
        FMT_DDR_QUAD_IO: begin
          bits = ADDR_BITS + MODE_BITS;
          w    = 8;
        end
        default: ;
      endcase
      if (four_wire_command_mode && w < 4) begin
        w = 4;
      end
      addrCycOf = 6'((bits + w - 1) / w);
    end
  endfunction : addrCycOf

  // reset from the dedicated pin, or io3 when allowed to act as reset
  assign resetActive = !rstPinS_n ||
                       (io3ResetEnable && !io3S &&
                        (!(quadEnable || fourWireMode) || csS)); // see RQ9

  always_comb begin
    pwrNxt = powerState_r;
    case (powerState_r)
      PWR_OFF: begin
        if (vccLowS && vccMinS) begin
          pwrNxt = PWR_POR;
        end
      end
      PWR_PROTECT: begin
        if (!vccLowS) begin
          pwrNxt = PWR_OFF;
        end else if (vccCutS) begin
          pwrNxt = PWR_READY;
        end
      end
      PWR_POR: begin
        if (!vccLowS) begin
          pwrNxt = PWR_OFF;
        end else if (porCnt_r == POR_MAX) begin
          pwrNxt = PWR_READY; // see RQ10
        end
      end
      PWR_READY: begin
        if (!vccLowS) begin
          pwrNxt = PWR_OFF;
        end else if (!vccCutS) begin
          pwrNxt = PWR_PROTECT; // see RQ11
        end else if (pulseCnt_r == PULSE_MAX) begin
          pwrNxt = PWR_HWRESET; // see RQ8
        end
      end
      PWR_HWRESET: begin
        if (!vccLowS) begin
          pwrNxt = PWR_OFF;
        end else if (procCnt_r == PROC_MAX && holdCnt_r == HOLD_MAX) begin
          pwrNxt = PWR_READY; // see RQ8
        end
      end
      default: pwrNxt = PWR_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      powerState_r <= PWR_OFF;
      linkHold_r   <= 1'b1;
      ready_r      <= 1'b0;
    end else begin
      powerState_r <= pwrNxt;
      linkHold_r   <= (pwrNxt != PWR_READY); // see RQ10
      ready_r      <= (pwrNxt == PWR_READY);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      porCnt_r   <= '0;
      pulseCnt_r <= '0;
      procCnt_r  <= '0;
      holdCnt_r  <= '0;
    end else begin
      porCnt_r   <= (powerState_r == PWR_POR) ? porCnt_r + 1'b1 : '0;
      pulseCnt_r <= !resetActive ? '0 :
                    (pulseCnt_r == PULSE_MAX) ? pulseCnt_r : pulseCnt_r + 1'b1;
      procCnt_r  <= (powerState_r != PWR_HWRESET) ? '0 :
                    (procCnt_r == PROC_MAX) ? procCnt_r : procCnt_r + 1'b1;
      holdCnt_r  <= (powerState_r != PWR_HWRESET || resetActive) ? '0 :
                    (holdCnt_r == HOLD_MAX) ? holdCnt_r : holdCnt_r + 1'b1;
    end
  end

  // a frame ends when select rises and the link saw at least one edge
  assign csRise   = csS && !csPrev_r;
  assign frameEnd = csRise && (tagS != lastTag_r) && (powerState_r == PWR_READY); // see RQ11

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      csPrev_r      <= 1'b1;
      lastTag_r     <= 1'b0;
      cmdValid_r    <= 1'b0;
      cmdRejected_r <= 1'b0;
      cmdCode_r     <= 8'h00;
      cmdWp_r       <= 1'b0;
    end else begin
      csPrev_r      <= csS;
      cmdValid_r    <= 1'b0;
      cmdRejected_r <= 1'b0;
      // the link tag is cleared outside ready, so follow it there
      if (csRise || powerState_r != PWR_READY) begin
        lastTag_r <= tagS;
      end
      if (frameEnd) begin
        cmdCode_r <= cmdS;
        cmdWp_r   <= wpS;
        if (instrDoneS && (isReadS || alignedS)) begin
          cmdValid_r <= 1'b1;
        end else begin
          cmdRejected_r <= 1'b1; // see RQ19
        end
      end
    end
  end

  // ---------------- link logic ----------------
  assign frameClr = chipSelect_n || linkHold_r;
  assign isRead   = (fmt_r != FMT_NONE) && (fmt_r != FMT_WRITE);
  assign io0      = ioIn[0];

  // fresh marks the first edge after select fell
  always_ff @(posedge serialClock or posedge frameClr) begin
    if (frameClr) begin
      fresh_r <= 1'b1; // see RQ1
    end else begin
      fresh_r <= 1'b0;
    end
  end

  always_comb begin
    curState = fresh_r ? L_INSTR : state_r; // see RQ2
    curCnt   = fresh_r ? 6'h00 : cnt_r;
    curCmd   = fresh_r ? 8'h00 : cmd_r;
    curMod   = fresh_r ? 3'h0 : mod_r;
  end

  always_comb begin
    stateNxt = curState;
    cntNxt   = curCnt + 6'h01;
    instrNxt = curCmd;
    fmtNxt   = fmt_r;
    doneNxt  = fresh_r ? 1'b0 : instrDone_r;
    wpNxt    = fresh_r ? 1'b0 : wpCapt_r;
    modNxt   = curMod + (qpiS ? 3'h4 : 3'h1);
    case (curState)
      L_INSTR: begin
        // legacy shifts io0 msb first, four-wire mode a nibble per edge
        instrNxt = qpiS ? {curCmd[3:0], ioIn} : {curCmd[6:0], ioIn[0]}; // see RQ3 see RQ18
        if (curCnt == (qpiS ? QPI_LAST : LEGACY_LAST)) begin
          doneNxt = 1'b1;
          cntNxt  = 6'h00;
          fmtNxt  = fmtOf(instrNxt); // see RQ6
          if (!qpiS && isWpCmd(instrNxt)) begin
            wpNxt = !ioIn[IO_WP_IDX]; // see RQ4
          end
          case (fmtNxt)
            FMT_NONE:  stateNxt = L_DONE;
            FMT_WRITE: stateNxt = L_WDATA;
            default:   stateNxt = L_ADDR;
          endcase
        end
      end
      L_ADDR: begin
        if (curCnt == addrCycOf(fmt_r, qpiS) - 6'h01) begin
          cntNxt   = 6'h00;
          stateNxt = (latS == 4'h0) ? L_OUT : L_LAT; // see RQ6
        end
      end
      L_LAT: begin
        // line values are not looked at here
        if (curCnt == {2'b00, latS} - 6'h01) begin
          cntNxt   = 6'h00;
          stateNxt = L_OUT; // see RQ17
        end
      end
      L_OUT, L_WDATA, L_DONE: cntNxt = curCnt;
      default: stateNxt = L_DONE;
    endcase
  end

  always_ff @(posedge serialClock or posedge linkHold_r) begin
    if (linkHold_r) begin
      state_r     <= L_INSTR;
      cnt_r       <= 6'h00;
      cmd_r       <= 8'h00;
      mod_r       <= 3'h0;
      fmt_r       <= FMT_NONE;
      instrDone_r <= 1'b0;
      wpCapt_r    <= 1'b0;
    end else if (!chipSelect_n) begin // see RQ1
      state_r     <= stateNxt;
      cnt_r       <= cntNxt;
      cmd_r       <= instrNxt;
      mod_r       <= modNxt; // see RQ19
      fmt_r       <= fmtNxt;
      instrDone_r <= doneNxt;
      wpCapt_r    <= wpNxt;
    end
  end

  always_ff @(posedge serialClock or posedge linkHold_r) begin
    if (linkHold_r) begin
      frameTgl_r <= 1'b0;
    end else if (fresh_r && !chipSelect_n) begin // see RQ1
      frameTgl_r <= !frameTgl_r;
    end
  end

  // output width: so alone, io0-io1, or all four lines
  always_comb begin
    if (qpiS || fmt_r == FMT_QUAD_OUT || fmt_r == FMT_QUAD_IO || fmt_r == FMT_DDR_QUAD_IO) begin
      outMask = 4'hF;
    end else if (fmt_r == FMT_DUAL_OUT || fmt_r == FMT_DUAL_IO) begin
      outMask = 4'h3;
    end else begin
      outMask = 4'h2;
    end
  end

  always_comb begin
    shCur = outLoaded_r ? outSh_r : readS;
    case (outMask)
      4'hF: begin
        drive  = shCur[7:4];
        shNext = {shCur[3:0], shCur[7:4]};
      end
      4'h3: begin
        drive  = {2'b00, shCur[7:6]};
        shNext = {shCur[5:0], shCur[7:6]};
      end
      default: begin
        drive  = {2'b00, shCur[7], 1'b0};
        shNext = {shCur[6:0], shCur[7]};
      end
    endcase
  end

  // data changes on falling edges; select high floats everything at once
  always_ff @(negedge serialClock or posedge frameClr) begin
    if (frameClr) begin
      ioOe_n_r    <= 4'hF; // see RQ20
      ioOut_r     <= 4'h0;
      outSh_r     <= 8'h00;
      outLoaded_r <= 1'b0;
    end else if (state_r == L_OUT) begin
      ioOe_n_r    <= ~outMask; // see RQ13
      ioOut_r     <= drive;
      outSh_r     <= shNext;
      outLoaded_r <= 1'b1;
    end else begin
      ioOe_n_r    <= 4'hF; // see RQ12
      ioOut_r     <= 4'h0;
    end
  end

  assign ioOut             = ioOut_r;
  assign ioOe_n            = ioOe_n_r;
  assign powerState        = powerState_r;
  assign deviceReady       = ready_r;
  assign cmdValid          = cmdValid_r;
  assign cmdRejected       = cmdRejected_r;
  assign cmdCode           = cmdCode_r;
  assign cmdWriteProtected = cmdWp_r;

  chk_float_no_out: assert property ( // see RQ12
    @(posedge serialClock) disable iff (linkHold_r)
    (state_r != L_OUT) |-> (ioOe_n_r == 4'hF)
  ) else $error("io driven outside output cycle");

  chk_out_width: assert property ( // see RQ13
    @(posedge serialClock) disable iff (linkHold_r)
    (state_r == L_OUT && !fresh_r) |-> (ioOe_n_r == ~outMask)
  ) else $error("output width wrong");

  chk_instr_msb: assert property ( // see RQ3
    @(posedge serialClock) disable iff (linkHold_r)
    (!qpiS && !fresh_r && curState == L_INSTR && curCnt == LEGACY_LAST) |=>
    (cmd_r[7] == $past(io0, 8)) && (cmd_r[0] == $past(io0))
  ) else $error("instruction bit order wrong");

  chk_start_instr: assert property ( // see RQ2
    @(posedge serialClock) disable iff (linkHold_r)
    (fresh_r && !chipSelect_n) |=> (state_r == L_INSTR) && (cnt_r == 6'h01)
  ) else $error("frame did not start in instruction cycle");

  chk_lat_to_out: assert property ( // see RQ17
    @(posedge serialClock) disable iff (linkHold_r)
    (!fresh_r && state_r == L_LAT && cnt_r == {2'b00, latS} - 6'h01) |=> (state_r == L_OUT)
  ) else $error("latency did not end in output cycle");

  chk_wp_ignored: assert property ( // see RQ4
    @(posedge serialClock) disable iff (linkHold_r)
    (!fresh_r && state_r != L_INSTR) |=> $stable(wpCapt_r)
  ) else $error("write protect sampled outside instruction");

  chk_misaligned_reject: assert property ( // see RQ19
    @(posedge clk) disable iff (!reset_n)
    (frameEnd && !isReadS && !alignedS) |=> cmdRejected_r && !cmdValid_r
  ) else $error("misaligned command not rejected");

  chk_lowvcc_ignore: assert property ( // see RQ11
    @(posedge clk) disable iff (!reset_n)
    (powerState_r != PWR_READY) |=> !cmdValid_r
  ) else $error("command accepted while not ready");

  chk_reset_hold: assert property ( // see RQ8
    @(posedge clk) disable iff (!reset_n)
    (powerState_r == PWR_HWRESET && (holdCnt_r != HOLD_MAX || procCnt_r != PROC_MAX)) |=>
    (powerState_r != PWR_READY)
  ) else $error("reset left before processing and hold");

  chk_por_length: assert property ( // see RQ10
    @(posedge clk) disable iff (!reset_n)
    (powerState_r == PWR_POR && porCnt_r != POR_MAX) |=> (powerState_r != PWR_READY) && linkHold_r
  ) else $error("power-up interval cut short");
endmodule : flash_if_states

/* flash_if_sync.sv */
// Functional notes
// RQ1 - chip select high: interface idles, only reset inputs are watched
// RQ2 - chip select falling in standby starts the instruction cycle
// RQ3 - legacy instruction: eight bits, msb first, one per rising clock edge
// RQ4 - write-protect sampled only on instruction of register-altering commands
// RQ5 - host holds shared io3_or_reset_line high outside quad modes unless resetting
// RQ6 - instruction picks transfer format, which fixes the following states
// RQ7 - host raises chip select after eighth bit of standalone commands
// RQ8 - reset low for pulse time starts reset; ready after processing and hold
// RQ9 - io3 acts as reset outside quad modes, or in them with select high
// RQ10 - during power-up interval nothing is answered or driven, then standby
// RQ11 - supply below cut-off: all commands are ignored
// RQ12 - outputs float outside output cycles
// RQ13 - output cycles drive so, io0-io1 or all four lines by width
// RQ14 - host toggles clock, holds select low and reset high during commands
// RQ15 - host drives valid levels on the lines of each input cycle
// RQ16 - host holds select high during power-up and quad-mode reset
// RQ17 - latency cycle line values are ignored and lines are not driven
// RQ18 - four-wire command mode takes instruction four bits per clock
// RQ19 - non-read command rejected if select rises off a byte boundary
// RQ20 - select rising in any cycle returns the interface to standby
package flash_if_pkg;
  localparam int CLK_PERIOD_NS         = 10;
  localparam int RESET_PULSE_NS        = 200;
  localparam int RESET_PROCESSING_NS   = 35000;
  localparam int RESET_RELEASE_HOLD_NS = 50;
  localparam int POWER_UP_NS_DEFAULT   = 300000;
  localparam int RESET_PULSE_CYC       = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PROCESSING_CYC  = (RESET_PROCESSING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_HOLD_CYC        = (RESET_RELEASE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_BITS             = 24;
  localparam int MODE_BITS             = 8;
  localparam logic [5:0] LEGACY_LAST   = 6'h07;
  localparam logic [5:0] QPI_LAST      = 6'h01;
  localparam int IO_SO_IDX             = 1;
  localparam int IO_WP_IDX             = 2;
  localparam int IO_RST_IDX            = 3;
  localparam logic [7:0] OP_READ              = 8'h11;
  localparam logic [7:0] OP_DUAL_OUT          = 8'h12;
  localparam logic [7:0] OP_QUAD_OUT          = 8'h14;
  localparam logic [7:0] OP_DUAL_IO           = 8'h22;
  localparam logic [7:0] OP_QUAD_IO           = 8'h44;
  localparam logic [7:0] OP_DDR_QUAD_IO       = 8'h48;
  localparam logic [7:0] WRITE_REGISTER_CMD   = 8'h31;
  localparam logic [7:0] WRITE_ANY_REGISTER_CMD = 8'h32;
  localparam logic [7:0] DATA_LEARNING_REG_WR = 8'h33;

  typedef enum logic [2:0] {
    PWR_OFF, PWR_PROTECT, PWR_POR, PWR_HWRESET, PWR_READY
  } pwr_t;
  typedef enum logic [2:0] {
    L_INSTR, L_ADDR, L_LAT, L_OUT, L_WDATA, L_DONE
  } lnk_t;
  typedef enum logic [2:0] {
    FMT_NONE, FMT_WRITE, FMT_SINGLE, FMT_DUAL_OUT, FMT_QUAD_OUT,
    FMT_DUAL_IO, FMT_QUAD_IO, FMT_DDR_QUAD_IO
  } fmt_t;

  function automatic fmt_t fmtOf(input logic [7:0] op);
    case (op)
      OP_READ:                fmtOf = FMT_SINGLE;
      OP_DUAL_OUT:            fmtOf = FMT_DUAL_OUT;
      OP_QUAD_OUT:            fmtOf = FMT_QUAD_OUT;
      OP_DUAL_IO:             fmtOf = FMT_DUAL_IO;
      OP_QUAD_IO:             fmtOf = FMT_QUAD_IO;
      OP_DDR_QUAD_IO:         fmtOf = FMT_DDR_QUAD_IO;
      WRITE_REGISTER_CMD,
      WRITE_ANY_REGISTER_CMD,
      DATA_LEARNING_REG_WR:   fmtOf = FMT_WRITE;
      default:                fmtOf = FMT_NONE;
    endcase
  endfunction : fmtOf

  function automatic logic isWpCmd(input logic [7:0] op);
    isWpCmd = (op == WRITE_REGISTER_CMD) || (op == WRITE_ANY_REGISTER_CMD) ||
              (op == DATA_LEARNING_REG_WR);
  endfunction : isWpCmd
endpackage : flash_if_pkg

`timescale 1ns/10ps
module flash_if_sync #(
  parameter int WIDTH = 1
) (
  input  logic             clk,
  input  logic             clear,
  input  logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  if (WIDTH < 1) begin : g_bad_width
    $error("flash_if_sync needs WIDTH of at least one");
  end

  always_ff @(posedge clk or posedge clear) begin
    if (clear) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;
endmodule : flash_if_sync

/* tb_serial_flash_interface_states.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin nMismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_serial_flash_interface_states;
  import flash_if_pkg::*;
  localparam logic [7:0] RD_OP[6] = '{OP_READ, OP_DUAL_OUT, OP_QUAD_OUT,
                                      OP_DUAL_IO, OP_QUAD_IO, OP_DDR_QUAD_IO};
  localparam int         RD_NA[6] = '{24, 24, 24, 16, 8, 4};
  localparam int         RD_WA[6] = '{1, 1, 1, 2, 4, 4};
  localparam int         RD_WO[6] = '{1, 2, 4, 2, 4, 4};
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       vccAboveLow = 1'b0;
  logic       vccAboveCutoff = 1'b0;
  logic       vccAboveMin = 1'b0;
  logic       resetPin_n = 1'b1;
  logic       io3ResetEnable = 1'b0;
  logic       quadEnable = 1'b0;
  logic       fourWireMode = 1'b0;
  logic [3:0] latencyCycles = 4'h0;
  logic [7:0] readByte = 8'h00;
  logic       serialClock, chipSelect_n, deviceReady, cmdValid, cmdRejected, cmdWriteProtected;
  logic [3:0] ioIn, ioOut, ioOe_n;
  logic [7:0] cmdCode;
  pwr_t       powerState;
  int         nMismatch = 0;
  int         numChecks = 0;
  logic       gotV, gotR;

  always #5 clk = ~clk;

  flash_if_states #(.POWER_UP_NS(100)) uut (.clk, .reset_n, .vccAboveLow, .vccAboveCutoff,
    .vccAboveMin, .resetPin_n, .io3ResetEnable, .quadEnable, .fourWireMode, .latencyCycles,
    .readByte, .serialClock, .chipSelect_n, .ioIn, .ioOut, .ioOe_n, .powerState, .deviceReady,
    .cmdValid, .cmdRejected, .cmdCode, .cmdWriteProtected);
  flash_host_model host (.clk, .ioOut, .ioOe_n, .serialClock, .chipSelect_n, .ioIn);

  task automatic finishTest;
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finishTest

  task automatic result(input logic expV, input logic expR);
    gotV = 1'b0;
    gotR = 1'b0;
    repeat (12) begin
      @(negedge clk);
      gotV |= cmdValid;
      gotR |= cmdRejected;
    end
    `CHK(gotV, expV)
    `CHK(gotR, expR)
  endtask : result

  task automatic waitReady(input int bound, output int n);
    n = 0;
    while (deviceReady !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > bound) begin
        nMismatch++;
        $display("[ERR] %0t timeout", $time);
        finishTest();
      end
    end
  endtask : waitReady

  // samples before nPre must float; later ones carry readByte, msb first, w bits a cycle
  task automatic outChk(input int nPre, input int w);
    logic [3:0] oe;
    int v;
    oe = w == 1 ? 4'hD : w == 2 ? 4'hC : 4'h0;
    foreach (host.smp[k]) begin
      if (k < nPre) begin
        `CHK(host.smp[k][7:4], 4'hF)
      end else begin
        v = (int'(readByte) >> (8 - ((k - nPre) * w) % 8 - w)) & ((1 << w) - 1);
        `CHK(host.smp[k][7:4], oe)
        `CHK(host.smp[k][3:0] & ~oe, 4'(w == 1 ? v << 1 : v))
      end
    end
    `CHK(ioOe_n, 4'hF)
  endtask : outChk

  initial begin
    logic [7:0] op;
    int x;
    int cnt;
    void'($urandom(32'h91E4748A));
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    `CHK(powerState, PWR_OFF)
    vccAboveLow = 1'b1;
    vccAboveCutoff = 1'b1;
    vccAboveMin = 1'b1;
    waitReady(100, cnt);
    `CHK(cnt >= 10, 1'b1)
    repeat (3) host.cyc(4'hC, 4'hC);
    result(1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      op = 8'h80 | 8'($urandom);
      x = i % 4 == 3 ? 8 : i % 4;
      host.frame(op, 1'b0, 1'b1, x, 0, 1, 0, 0, 4'hC);
      result(x % 8 == 0, x % 8 != 0);
      if (x == 0) `CHK(cmdCode, op)
      outChk(99, 1);
    end
    for (int i = 0; i < 6; i++) begin
      readByte = 8'($urandom);
      latencyCycles = 4'(i % 4);
      host.frame(RD_OP[i], 1'b0, 1'b1, 0, RD_NA[i], RD_WA[i], i % 4, 5,
                 RD_WO[i] == 4 ? 4'h0 : 4'hC);
      result(1'b1, 1'b0);
      outChk(8 + RD_NA[i] + i % 4, RD_WO[i]);
      `CHK(cmdCode, RD_OP[i])
    end
    for (int i = 0; i < 4; i++) begin
      op = i < 3 ? WRITE_REGISTER_CMD + 8'(i) : 8'h90;
      host.frame(op, 1'b0, i[0], 8, 0, 1, 0, 0, 4'hC);
      result(1'b1, 1'b0);
      `CHK(cmdWriteProtected, i < 3 && !i[0])
    end
    quadEnable = 1'b1;
    fourWireMode = 1'b1;
    repeat (2) host.cyc(4'hC, 4'hC);
    host.frame(8'hA5, 1'b1, 1'b1, 0, 0, 1, 0, 0, 4'h0);
    result(1'b1, 1'b0);
    `CHK(cmdCode, 8'hA5)
    quadEnable = 1'b0;
    fourWireMode = 1'b0;
    repeat (2) host.cyc(4'hC, 4'hC);
    for (int s = 0; s < 2; s++) begin
      io3ResetEnable = s[0];
      if (s == 0) resetPin_n = 1'b0;
      else host.hostD = 4'h4;
      x = s == 0 ? 3600 : 25;
      repeat (x) @(negedge clk);
      `CHK(powerState, PWR_HWRESET)
      resetPin_n = 1'b1;
      host.hostD = 4'hC;
      waitReady(4000, cnt);
      `CHK(cnt >= RESET_HOLD_CYC && x + cnt > RESET_PROCESSING_CYC, 1'b1)
    end
    io3ResetEnable = 1'b0;
    vccAboveCutoff = 1'b0;
    repeat (5) @(negedge clk);
    `CHK(powerState, PWR_PROTECT)
    host.frame(8'h90, 1'b0, 1'b1, 0, 0, 1, 0, 0, 4'hC);
    result(1'b0, 1'b0);
    outChk(99, 1);
    vccAboveCutoff = 1'b1;
    waitReady(20, cnt);
    finishTest();
  end
endmodule : tb_serial_flash_interface_states
